// file: include/cisfw_pkg.sv
// Purpose: shared constants and types of the enable, shutdown and firmware-activation sequencer
// Assumes: one 25 MHz controller clock
// Notes: all timing counts derive from a time in ns and the clock period
package cisfw_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int CTRL_RESET_NS = 1000;
  localparam int NORMAL_SHUT_NS = 2000;
  localparam int ABRUPT_SHUT_NS = 400;
  // least times, rounded up to whole cycles
  localparam int CTRL_RESET_CYC = (CTRL_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NORMAL_SHUT_CYC = (NORMAL_SHUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ABRUPT_SHUT_CYC = (ABRUPT_SHUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // shutdown encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SHN_NONE = 2'h0;
  localparam logic [1:0] SHN_NORMAL = 2'h1;
  localparam logic [1:0] SHN_ABRUPT = 2'h2;
  localparam logic [1:0] SHST_IDLE = 2'h0;
  localparam logic [1:0] SHST_BUSY = 2'h1;
  localparam logic [1:0] SHST_DONE = 2'h2;

  // ----------------------------------------------------------------
  // command completion status and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CST_OK = 2'h0;
  localparam logic [1:0] CST_BAD_IMAGE = 2'h1;
  localparam logic [1:0] CST_BAD_SLOT = 2'h2;
  localparam logic [2:0] BOOT_SLOT = 3'h1;
  localparam logic [7:0] SLOT_OK_RESET = 8'h02;

  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_LOAD = 3'h1,
    ST_IDLE = 3'h2,
    ST_READY = 3'h3,
    ST_SHUT = 3'h4,
    ST_HALT = 3'h5
  } cisfw_state_e;

  typedef enum logic [1:0] {
    OP_DOWNLOAD = 2'h0,
    OP_ACTIVATE = 2'h1,
    OP_DEL_SQ = 2'h2,
    OP_OTHER = 2'h3
  } cisfw_op_e;
endpackage

// file: logic/cisfw_sequencer.sv
// Purpose: controller enable/ready, shutdown and firmware download/activate sequencing
// Assumes: inputs synchronous to I_SYS_CLK; host keeps its own ordering duties
// Notes: firmware slot storage and image loading live outside; this block steers them
// Operation
// RL1 - ready low signals earlier reset finished
// RL2 - host sets admin queues before enable
// RL3 - host sets arbitration, page size, command set
// RL4 - enable then ready; commands only when ready
// RL5 - host may send event requests after ready
// RL6 - queue count unchanged across D3 exit
// RL7 - normal shutdown request ends status 10b
// RL8 - abrupt shutdown request ends status 10b
// RL9 - host drains and deletes queues first
// RL10 - queue deletion aborts its outstanding commands
// RL11 - host allows one second for shutdown
// RL12 - host avoids clearing enable to shut down
// RL13 - after shutdown no commands until reset
// RL14 - activate validates latest image, commits slot
// RL15 - image invalid if start, gap, overlap wrong
// RL16 - activated image applies only after reset
// RL17 - load failure reverts image, raises event
// RL18 - reset before activate discards partial image
// RL19 - host commits one image before next
// RL20 - pieces placed by their carried offset
// RL21 - D3 cold mid-activation may keep either
// RL22 - activating earlier slot reapplies its image
// RL23 - enable cleared: reset, then ready low
// RL24 - status not 10b without shutdown request
`timescale 1ns/1ps
module cisfw_sequencer #(
  parameter int NUM_IO_QUEUES = 16,
  parameter int QID_W = 16
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_CONTROLLER_ENABLE_BIT,
  input wire logic [1:0] I_SHUTDOWN_NOTIFY_FIELD,
  input wire logic [2:0] I_ARBITRATION_SCHEME_SELECT,
  input wire logic [3:0] I_HOST_PAGE_SIZE_FIELD,
  input wire logic [2:0] I_COMMAND_SET_SELECT,
  input wire logic I_FUNC_RESET,
  input wire logic I_CMD_VALID,
  input wire logic [1:0] I_CMD_OPCODE,
  input wire logic [31:0] I_DL_OFFSET,
  input wire logic [31:0] I_DL_LENGTH,
  input wire logic [2:0] I_ACT_SLOT,
  input wire logic [QID_W-1:0] I_CMD_QID,
  input wire logic I_FW_LOAD_DONE,
  input wire logic I_FW_LOAD_OK,
  output logic O_CONTROLLER_READY_FLAG,
  output logic [1:0] O_SHUTDOWN_STATUS_FIELD,
  output logic O_CMD_ACCEPT,
  output logic O_CMD_DONE,
  output logic [1:0] O_CMD_STATUS,
  output logic O_SQ_ABORT,
  output logic [QID_W-1:0] O_ABORT_QID,
  output logic [2:0] O_ARBITRATION_SCHEME_SELECT,
  output logic [3:0] O_HOST_PAGE_SIZE_FIELD,
  output logic [2:0] O_COMMAND_SET_SELECT,
  output logic O_FW_LOAD_REQ,
  output logic [2:0] O_FW_LOAD_SLOT,
  output logic [2:0] O_ACTIVE_SLOT,
  output logic O_FW_LOAD_ERROR_EVT,
  output logic [15:0] O_NUM_IO_QUEUES
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cisfw_pkg::cisfw_state_e state, next_state;
  logic [cisfw_pkg::CNT_W-1:0] cnt, next_cnt;
  logic ready, next_ready;
  logic [1:0] shst, next_shst;
  logic [31:0] expect_off, next_expect_off;
  logic dl_any, next_dl_any;
  logic dl_bad, next_dl_bad;
  logic [7:0] slot_ok, next_slot_ok;
  logic [2:0] active_slot, next_active_slot;
  logic apply_pend, next_apply_pend;
  logic [2:0] pend_slot, next_pend_slot;
  logic done, next_done;
  logic [1:0] status, next_status;
  logic abort, next_abort;
  logic [QID_W-1:0] abort_qid, next_abort_qid;
  logic [2:0] ams, next_ams;
  logic [3:0] mps, next_mps;
  logic [2:0] css, next_css;
  logic load_err, next_load_err;
  logic take;

  assign take = I_CMD_VALID && (state == cisfw_pkg::ST_READY);

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ready = ready;
    next_shst = shst;
    next_expect_off = expect_off;
    next_dl_any = dl_any;
    next_dl_bad = dl_bad;
    next_slot_ok = slot_ok;
    next_active_slot = active_slot;
    next_apply_pend = apply_pend;
    next_pend_slot = pend_slot;
    next_done = 1'b0;
    next_status = status;
    next_abort = 1'b0;
    next_abort_qid = abort_qid;
    next_ams = ams;
    next_mps = mps;
    next_css = css;
    next_load_err = 1'b0;
    case (state)
      cisfw_pkg::ST_RESET: begin
        if (cnt == '0) begin
          next_ready = 1'b0; // RL23 RL1
          // a committed image is brought up only here, after a reset
          next_state = apply_pend ? cisfw_pkg::ST_LOAD : cisfw_pkg::ST_IDLE; // RL16
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      cisfw_pkg::ST_LOAD: begin
        if (I_FW_LOAD_DONE) begin
          next_apply_pend = 1'b0;
          if (I_FW_LOAD_OK) begin
            next_active_slot = pend_slot;
          end else begin
            // previous image stays active
            next_load_err = 1'b1; // RL17
          end
          next_state = cisfw_pkg::ST_IDLE;
        end
      end
      cisfw_pkg::ST_IDLE: begin
        if (I_CONTROLLER_ENABLE_BIT) begin
          next_ams = I_ARBITRATION_SCHEME_SELECT; // RL3
          next_mps = I_HOST_PAGE_SIZE_FIELD;
          next_css = I_COMMAND_SET_SELECT;
          next_ready = 1'b1; // RL4
          next_state = cisfw_pkg::ST_READY;
        end
      end
      cisfw_pkg::ST_READY: begin
        if (I_SHUTDOWN_NOTIFY_FIELD != cisfw_pkg::SHN_NONE) begin
          next_shst = cisfw_pkg::SHST_BUSY;
          next_state = cisfw_pkg::ST_SHUT;
          // abrupt skips the orderly flush, so it finishes sooner
          if (I_SHUTDOWN_NOTIFY_FIELD == cisfw_pkg::SHN_ABRUPT) begin
            next_cnt = cisfw_pkg::CNT_W'(cisfw_pkg::ABRUPT_SHUT_CYC - 1); // RL8
          end else begin
            next_cnt = cisfw_pkg::CNT_W'(cisfw_pkg::NORMAL_SHUT_CYC - 1); // RL7
          end
        end
      end
      cisfw_pkg::ST_SHUT: begin
        if (cnt == '0) begin
          next_shst = cisfw_pkg::SHST_DONE; // RL7 RL8
          next_state = cisfw_pkg::ST_HALT; // RL13
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      cisfw_pkg::ST_HALT: begin
        next_state = cisfw_pkg::ST_HALT; // RL13
      end
      default: begin
        next_state = cisfw_pkg::ST_RESET;
      end
    endcase
    if (take) begin
      next_done = 1'b1;
      next_status = cisfw_pkg::CST_OK;
      case (I_CMD_OPCODE)
        cisfw_pkg::OP_DOWNLOAD: begin
          next_dl_any = 1'b1;
          // pieces must chain from zero with no gap or overlap
          if (I_DL_OFFSET != expect_off) begin
            next_dl_bad = 1'b1; // RL15
          end
          next_expect_off = I_DL_OFFSET + I_DL_LENGTH; // RL20
        end
        cisfw_pkg::OP_ACTIVATE: begin
          if (I_ACT_SLOT == 3'h0) begin
            next_status = cisfw_pkg::CST_BAD_SLOT;
          end else if (dl_any) begin
            if (dl_bad || (expect_off == 32'h0000_0000)) begin
              next_status = cisfw_pkg::CST_BAD_IMAGE; // RL15
            end else begin
              next_slot_ok[I_ACT_SLOT] = 1'b1; // RL14
              next_apply_pend = 1'b1;
              next_pend_slot = I_ACT_SLOT;
            end
            next_dl_any = 1'b0;
            next_dl_bad = 1'b0;
            next_expect_off = 32'h0000_0000;
          end else if (slot_ok[I_ACT_SLOT]) begin
            next_apply_pend = 1'b1; // RL22
            next_pend_slot = I_ACT_SLOT;
          end else begin
            next_status = cisfw_pkg::CST_BAD_SLOT;
          end
        end
        cisfw_pkg::OP_DEL_SQ: begin
          next_abort = 1'b1; // RL10
          next_abort_qid = I_CMD_QID;
        end
        default: begin
          next_status = cisfw_pkg::CST_OK;
        end
      endcase
    end
    // controller reset from enable falling, or a function level reset
    if (I_FUNC_RESET || (!I_CONTROLLER_ENABLE_BIT && (state == cisfw_pkg::ST_READY ||
        state == cisfw_pkg::ST_SHUT || state == cisfw_pkg::ST_HALT))) begin
      next_state = cisfw_pkg::ST_RESET; // RL23 RL13
      next_cnt = cisfw_pkg::CNT_W'(cisfw_pkg::CTRL_RESET_CYC - 1);
      next_shst = cisfw_pkg::SHST_IDLE; // RL24
      next_dl_any = 1'b0; // RL18
      next_dl_bad = 1'b0;
      next_expect_off = 32'h0000_0000;
      next_done = 1'b0;
      next_abort = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      state <= cisfw_pkg::ST_RESET;
      cnt <= cisfw_pkg::CNT_W'(cisfw_pkg::CTRL_RESET_CYC - 1);
      ready <= 1'b0;
      shst <= cisfw_pkg::SHST_IDLE;
      expect_off <= 32'h0000_0000;
      dl_any <= 1'b0;
      dl_bad <= 1'b0;
      slot_ok <= cisfw_pkg::SLOT_OK_RESET;
      active_slot <= cisfw_pkg::BOOT_SLOT;
      // power loss mid-activation drops the pending slot
      apply_pend <= 1'b0; // RL21
      pend_slot <= cisfw_pkg::BOOT_SLOT;
      done <= 1'b0;
      status <= cisfw_pkg::CST_OK;
      abort <= 1'b0;
      abort_qid <= '0;
      ams <= 3'h0;
      mps <= 4'h0;
      css <= 3'h0;
      load_err <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ready <= next_ready;
      shst <= next_shst;
      expect_off <= next_expect_off;
      dl_any <= next_dl_any;
      dl_bad <= next_dl_bad;
      slot_ok <= next_slot_ok;
      active_slot <= next_active_slot;
      apply_pend <= next_apply_pend;
      pend_slot <= next_pend_slot;
      done <= next_done;
      status <= next_status;
      abort <= next_abort;
      abort_qid <= next_abort_qid;
      ams <= next_ams;
      mps <= next_mps;
      css <= next_css;
      load_err <= next_load_err;
    end
  end

  assign O_CONTROLLER_READY_FLAG = ready;
  assign O_SHUTDOWN_STATUS_FIELD = shst;
  assign O_CMD_ACCEPT = (state == cisfw_pkg::ST_READY); // RL4 RL13
  assign O_CMD_DONE = done;
  assign O_CMD_STATUS = status;
  assign O_SQ_ABORT = abort;
  assign O_ABORT_QID = abort_qid;
  assign O_ARBITRATION_SCHEME_SELECT = ams;
  assign O_HOST_PAGE_SIZE_FIELD = mps;
  assign O_COMMAND_SET_SELECT = css;
  assign O_FW_LOAD_REQ = (state == cisfw_pkg::ST_LOAD);
  assign O_FW_LOAD_SLOT = pend_slot;
  assign O_ACTIVE_SLOT = active_slot;
  assign O_FW_LOAD_ERROR_EVT = load_err;
  assign O_NUM_IO_QUEUES = 16'(NUM_IO_QUEUES); // RL6

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  sequence shut_req_s;
    (state == cisfw_pkg::ST_READY) && I_CONTROLLER_ENABLE_BIT && !I_FUNC_RESET &&
      (I_SHUTDOWN_NOTIFY_FIELD != cisfw_pkg::SHN_NONE);
  endsequence
  sequence disable_s;
    (state == cisfw_pkg::ST_READY) && !I_CONTROLLER_ENABLE_BIT;
  endsequence

  ready_on_enable_a: assert property ((state == cisfw_pkg::ST_IDLE) && I_CONTROLLER_ENABLE_BIT && !I_FUNC_RESET
    |=> O_CONTROLLER_READY_FLAG && O_CMD_ACCEPT) else $error("ready not raised after enable"); // RL4
  done_only_ready_a: assert property (O_CMD_DONE |-> $past(state) == cisfw_pkg::ST_READY)
    else $error("command completed while not ready"); // RL13
  ready_drop_a: assert property (disable_s |=> O_CONTROLLER_READY_FLAG[*8] ##[1:30] !O_CONTROLLER_READY_FLAG)
    else $error("ready not dropped after controller reset"); // RL23
  shut_busy_a: assert property (shut_req_s |=> O_SHUTDOWN_STATUS_FIELD == cisfw_pkg::SHST_BUSY)
    else $error("shutdown not started"); // RL7
  shut_done_a: assert property ((state == cisfw_pkg::ST_SHUT) && (cnt == '0) && I_CONTROLLER_ENABLE_BIT
    && !I_FUNC_RESET |=> O_SHUTDOWN_STATUS_FIELD == cisfw_pkg::SHST_DONE && !O_CMD_ACCEPT)
    else $error("shutdown completion not reported"); // RL8
  shst_idle_a: assert property ((state != cisfw_pkg::ST_SHUT) && (state != cisfw_pkg::ST_HALT)
    |-> O_SHUTDOWN_STATUS_FIELD == cisfw_pkg::SHST_IDLE) else $error("shutdown status set without request"); // RL24
  sq_abort_a: assert property (take && !I_FUNC_RESET && I_CONTROLLER_ENABLE_BIT && (I_CMD_OPCODE == cisfw_pkg::OP_DEL_SQ)
    |=> O_SQ_ABORT && O_ABORT_QID == $past(I_CMD_QID)) else $error("queue deletion did not abort"); // RL10
  bad_image_a: assert property (take && !I_FUNC_RESET && I_CONTROLLER_ENABLE_BIT && (I_CMD_OPCODE == cisfw_pkg::OP_ACTIVATE)
    && (I_ACT_SLOT != 3'h0) && dl_any && dl_bad |=> O_CMD_STATUS == cisfw_pkg::CST_BAD_IMAGE && !dl_any)
    else $error("invalid image accepted"); // RL15
  discard_a: assert property ((state == cisfw_pkg::ST_RESET) |-> !dl_any)
    else $error("partial image survived reset"); // RL18
  load_fail_a: assert property ((state == cisfw_pkg::ST_LOAD) && I_FW_LOAD_DONE && !I_FW_LOAD_OK && !I_FUNC_RESET
    |=> O_FW_LOAD_ERROR_EVT && O_ACTIVE_SLOT == $past(O_ACTIVE_SLOT)) else $error("load failure not reverted"); // RL17
endmodule

// file: tb/tb_controller_init_shutdown_fw_activate.sv
// Purpose: self-checking bench for the enable, shutdown and firmware-activation sequencer
// Assumes: bench drives every port itself; inputs change at the rising edge by non-blocking assignment
// Notes: loader answers are given by the bench after the load request shows
`timescale 1ns/1ps
module tb_controller_init_shutdown_fw_activate;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0;
  logic [1:0] shn = 2'h0;
  logic fr = 1'b0;
  logic vld = 1'b0;
  logic [1:0] op = 2'h0;
  logic [31:0] off = 32'h0000_0000;
  logic [31:0] len = 32'h0000_0000;
  logic [2:0] slot = 3'h0;
  logic [15:0] qid = 16'h0000;
  logic ld_done = 1'b0;
  logic ld_ok = 1'b0;
  logic ready, accept, done, abort, ld_req, err;
  logic [1:0] shst, st;
  logic [15:0] abort_qid, nq;
  logic [2:0] arb, css, ld_slot, active;
  logic [3:0] mps;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int f_off[3] = '{0, 0, 16};
  int s_off[3] = '{32, 96, 80};

  cisfw_sequencer DUT (.I_SYS_CLK(clk), .I_RST(rst), .I_CONTROLLER_ENABLE_BIT(en),
    .I_SHUTDOWN_NOTIFY_FIELD(shn), .I_ARBITRATION_SCHEME_SELECT(3'h5), .I_HOST_PAGE_SIZE_FIELD(4'h3),
    .I_COMMAND_SET_SELECT(3'h1), .I_FUNC_RESET(fr), .I_CMD_VALID(vld), .I_CMD_OPCODE(op),
    .I_DL_OFFSET(off), .I_DL_LENGTH(len), .I_ACT_SLOT(slot), .I_CMD_QID(qid), .I_FW_LOAD_DONE(ld_done),
    .I_FW_LOAD_OK(ld_ok), .O_CONTROLLER_READY_FLAG(ready), .O_SHUTDOWN_STATUS_FIELD(shst),
    .O_CMD_ACCEPT(accept), .O_CMD_DONE(done), .O_CMD_STATUS(st), .O_SQ_ABORT(abort),
    .O_ABORT_QID(abort_qid), .O_ARBITRATION_SCHEME_SELECT(arb), .O_HOST_PAGE_SIZE_FIELD(mps),
    .O_COMMAND_SET_SELECT(css), .O_FW_LOAD_REQ(ld_req), .O_FW_LOAD_SLOT(ld_slot),
    .O_ACTIVE_SLOT(active), .O_FW_LOAD_ERROR_EVT(err), .O_NUM_IO_QUEUES(nq));

  initial begin
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task complete_run();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // run is a few hundred cycles; ceiling well above that
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task wait_ready(input logic v, input int lim);
    int n;
    n = 0;
    while (ready !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("ready", ready, v);
  endtask

  task cmd(input logic [1:0] o, input int of, input int ln, input logic [2:0] sl, input logic exp_done,
           input logic [1:0] exp_st);
    @(posedge clk);
    vld <= 1'b1;
    op <= o;
    off <= of;
    len <= ln;
    slot <= sl;
    qid <= 16'h0007;
    @(posedge clk);
    vld <= 1'b0;
    #1;
    check("cmd_done", done, exp_done);
    if (exp_done) check("cmd_status", st, exp_st);
    if (o == cisfw_pkg::OP_DEL_SQ) begin
      check("sq_abort", abort, 1'b1);
      check("abort_qid", abort_qid, 16'h0007);
    end
  endtask

  task shut(input logic [1:0] code, input int n);
    int cnt;
    cnt = 0;
    @(posedge clk);
    shn <= code;
    @(posedge clk);
    #1;
    check("shst_busy", shst, cisfw_pkg::SHST_BUSY);
    check("accept_off", accept, 1'b0);
    while (shst !== cisfw_pkg::SHST_DONE && cnt < 200) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    check("shst_done", shst, cisfw_pkg::SHST_DONE);
    check("shut_cycles", cnt, n);
  endtask

  // by_func picks function reset over clearing enable
  task ctl_reset(input logic by_func);
    @(posedge clk);
    if (by_func) fr <= 1'b1;
    else en <= 1'b0;
    shn <= 2'h0;
    @(posedge clk);
    fr <= 1'b0;
    #1;
    check("shst_idle", shst, cisfw_pkg::SHST_IDLE);
    repeat (18) @(posedge clk);
    #1;
    check("ready_held", ready, 1'b1);
    wait_ready(1'b0, 15);
  endtask

  task load(input logic ok, input logic [2:0] sl, input logic [2:0] exp_act, input logic exp_err);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    while (ld_req !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("load_req", ld_req, 1'b1);
    check("load_slot", ld_slot, sl);
    @(posedge clk);
    ld_done <= 1'b1;
    ld_ok <= ok;
    // event pulse lands within a couple of edges
    repeat (3) begin
      @(posedge clk);
      ld_done <= 1'b0;
      #1;
      if (err === 1'b1) seen = 1'b1;
    end
    check("load_err", seen, exp_err);
    check("active_slot", active, exp_act);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    en <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    check("ready_in_reset", ready, 1'b0);
    check("shst_reset", shst, cisfw_pkg::SHST_IDLE);
    check("boot_slot", active, cisfw_pkg::BOOT_SLOT);
    wait_ready(1'b1, 20);
    check("arb", arb, 3'h5);
    check("mps", mps, 4'h3);
    check("css", css, 3'h1);
    check("num_queues", nq, 16'h0010);
    cmd(cisfw_pkg::OP_ACTIVATE, 0, 0, 3'h1, 1'b1, cisfw_pkg::CST_OK);
    cmd(cisfw_pkg::OP_ACTIVATE, 0, 0, 3'h0, 1'b1, cisfw_pkg::CST_BAD_SLOT);
    cmd(cisfw_pkg::OP_ACTIVATE, 0, 0, 3'h5, 1'b1, cisfw_pkg::CST_BAD_SLOT);
    for (int i = 0; i < 3; i++) begin
      cmd(cisfw_pkg::OP_DOWNLOAD, f_off[i], 64, 3'h0, 1'b1, cisfw_pkg::CST_OK);
      cmd(cisfw_pkg::OP_DOWNLOAD, s_off[i], 8, 3'h0, 1'b1, cisfw_pkg::CST_OK);
      cmd(cisfw_pkg::OP_ACTIVATE, 0, 0, 3'h4, 1'b1, cisfw_pkg::CST_BAD_IMAGE);
    end
    cmd(cisfw_pkg::OP_DEL_SQ, 0, 0, 3'h0, 1'b1, cisfw_pkg::CST_OK);
    cmd(cisfw_pkg::OP_DOWNLOAD, 0, 64, 3'h0, 1'b1, cisfw_pkg::CST_OK);
    cmd(cisfw_pkg::OP_DOWNLOAD, 64, 64, 3'h0, 1'b1, cisfw_pkg::CST_OK);
    cmd(cisfw_pkg::OP_ACTIVATE, 0, 0, 3'h3, 1'b1, cisfw_pkg::CST_OK);
    check("active_before_reset", active, cisfw_pkg::BOOT_SLOT);
    shut(cisfw_pkg::SHN_NORMAL, cisfw_pkg::NORMAL_SHUT_CYC);
    cmd(cisfw_pkg::OP_OTHER, 0, 0, 3'h0, 1'b0, cisfw_pkg::CST_OK);
    ctl_reset(1'b0);
    load(1'b1, 3'h3, 3'h3, 1'b0);
    @(posedge clk);
    en <= 1'b1;
    wait_ready(1'b1, 40);
    cmd(cisfw_pkg::OP_DOWNLOAD, 0, 32, 3'h0, 1'b1, cisfw_pkg::CST_OK);
    ctl_reset(1'b1);
    wait_ready(1'b1, 40);
    cmd(cisfw_pkg::OP_ACTIVATE, 0, 0, 3'h6, 1'b1, cisfw_pkg::CST_BAD_SLOT);
    cmd(cisfw_pkg::OP_DOWNLOAD, 0, 32, 3'h0, 1'b1, cisfw_pkg::CST_OK);
    cmd(cisfw_pkg::OP_ACTIVATE, 0, 0, 3'h5, 1'b1, cisfw_pkg::CST_OK);
    shut(cisfw_pkg::SHN_ABRUPT, cisfw_pkg::ABRUPT_SHUT_CYC);
    ctl_reset(1'b0);
    load(1'b0, 3'h5, 3'h3, 1'b1);
    complete_run();
  end
endmodule
